// *** hdl/rcpu_pkg.sv ***
// rcpu_pkg: encodings, field positions and constants of the 8-bit core
// assumes nothing beyond a SystemVerilog compiler
package rcpu_pkg;
    localparam int RCPU_IW = 14;
    localparam int RCPU_DW = 8;
    localparam int RCPU_PCW = 13;
    localparam int RCPU_STACK_DEPTH = 6;
    localparam int RCPU_FAW = 7;
    localparam int RCPU_RAW = 6;
    localparam logic [12:0] RCPU_RESET_VEC = 13'h0000;
    localparam logic [12:0] RCPU_INT_VEC = 13'h0001;
    // status register layout (file address 3)
    localparam logic [6:0] RCPU_STATUS_ADDR = 7'h03;
    localparam int RCPU_C_BIT = 0;
    localparam int RCPU_DC_BIT = 1;
    localparam int RCPU_Z_BIT = 2;
    localparam int RCPU_PAGE_BIT = 6;
    localparam logic [7:0] RCPU_STATUS_RST = 8'h00;
    // full words of the fixed control instructions
    localparam logic [13:0] RCPU_OP_NOP = 14'h0000;
    localparam logic [13:0] RCPU_OP_SLEEP = 14'h0003;
    localparam logic [13:0] RCPU_OP_KICK = 14'h0004;
    localparam logic [13:0] RCPU_OP_RET = 14'h0040;
    localparam logic [13:0] RCPU_OP_RETURN_FROM_INTERRUPT = 14'h0060;
    localparam logic [13:0] RCPU_OP_CLRW = 14'h0140;
    // byte-oriented opcodes, bits 11:8
    localparam logic [3:0] RCPU_B_MOVE_ACC_TO_FILE = 4'h0;
    localparam logic [3:0] RCPU_B_CLR = 4'h1;
    localparam logic [3:0] RCPU_B_SUB = 4'h2;
    localparam logic [3:0] RCPU_B_DEC = 4'h3;
    localparam logic [3:0] RCPU_B_IOR = 4'h4;
    localparam logic [3:0] RCPU_B_AND = 4'h5;
    localparam logic [3:0] RCPU_B_XOR = 4'h6;
    localparam logic [3:0] RCPU_B_ADD = 4'h7;
    localparam logic [3:0] RCPU_B_MOVF = 4'h8;
    localparam logic [3:0] RCPU_B_COM = 4'h9;
    localparam logic [3:0] RCPU_B_INC = 4'hA;
    localparam logic [3:0] RCPU_B_DECSZ = 4'hB;
    localparam logic [3:0] RCPU_B_RRC = 4'hC;
    localparam logic [3:0] RCPU_B_RLC = 4'hD;
    localparam logic [3:0] RCPU_B_SWAP = 4'hE;
    localparam logic [3:0] RCPU_B_INCSZ = 4'hF;
    // literal opcodes, bits 10:8 under prefix 011
    localparam logic [2:0] RCPU_L_RETLIT = 3'h0;
    localparam logic [2:0] RCPU_L_MOV = 3'h1;
    localparam logic [2:0] RCPU_L_IOR = 3'h2;
    localparam logic [2:0] RCPU_L_AND = 3'h3;
    localparam logic [2:0] RCPU_L_ADD = 3'h4;
    localparam logic [2:0] RCPU_L_XOR = 3'h7;
    // group prefixes
    localparam logic [1:0] RCPU_G_BYTE = 2'h0;
    localparam logic [1:0] RCPU_G_CALL = 2'h2;
    localparam logic [1:0] RCPU_G_JUMP = 2'h3;
    localparam logic [2:0] RCPU_G_BIT = 3'h2;
    localparam logic [2:0] RCPU_G_LIT = 3'h3;
    // bit-op sub codes, bits 10:9
    localparam logic [1:0] RCPU_BT_CLR = 2'h0;
    localparam logic [1:0] RCPU_BT_SET = 2'h1;
    localparam logic [1:0] RCPU_BT_SKC = 2'h2;
    localparam logic [1:0] RCPU_BT_SKS = 2'h3;
    // phase of the halved crystal clock
    typedef enum logic {RCPU_PH_Q1 = 1'b0, RCPU_PH_Q2 = 1'b1} rcpu_phase_t;
endpackage : rcpu_pkg

// *** hdl/rcpu_stack.sv ***
// rcpu_stack: return address stack, registered top output
// assumes push and pop are never asserted together
`timescale 1ns/1ps
module rcpu_stack #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 6
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [WIDTH-1:0] i_data,
    output logic [WIDTH-1:0] o_top
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [$clog2(DEPTH)-1:0] ptr_q;

    // circular storage: overflow wraps and overwrites the oldest entry
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ptr_q <= '0;
            o_top <= '0;
            for (int k = 0; k < DEPTH; k++) begin
                mem_q[k] <= '0;
            end
        end else if (i_push) begin
            mem_q[ptr_q] <= i_data;
            o_top <= i_data;
            ptr_q <= (ptr_q == $clog2(DEPTH)'(DEPTH - 1)) ? '0
                                                         : ptr_q + 1'b1;
        end else if (i_pop) begin
            o_top <= mem_q[(ptr_q < 2) ?
                $clog2(DEPTH)'(DEPTH - 2 + 32'(ptr_q)) : ptr_q - 2'd2];
            ptr_q <= (ptr_q == '0) ? $clog2(DEPTH)'(DEPTH - 1)
                                   : ptr_q - 1'b1;
        end
    end
endmodule : rcpu_stack

// *** hdl/rcpu_core.sv ***
// rcpu_core: 8-bit core with decoder, ALU, accumulator, status and traps
// assumes program ROM and file plane read without a register: data valid
// by the next clock edge, file writes take effect on the next clock edge
// What this block does
// - ALU works on 8-bit data: add, subtract, rotate, logic operations.
// - accumulator is 8-bit, unaddressable; second operand is file or literal.
// - subtract carry and half carry are inverted borrow and nibble borrow.
// - status as destination: flag ops keep z, half carry, carry from flags; others write all bits.
// - each source sets its flag; request only when its enable is set.
// - after current instruction, enabled request injects call 0001, sets busy.
// - busy flag clears one instruction after interrupt return.
// - requests are level sensitive; handler must clear the event flag.
// - decode 14-bit words into byte, bit and literal groups.
// - destination bit 0 writes accumulator, 1 writes addressed file; movf with 1 writes neither.
// - bit ops: 3-bit position, 6-bit address, clear/set/skip clear/skip set.
// - move accumulator to write-only plane address, one cycle.
// - one cycle per instruction, branches two; call 10, jump 11.
// - power-down word halts clock; all-zero word writes accumulator to plane address 0.
// - watchdog kick clears and enables watchdog, no flags.
// - return and interrupt return pop stack into pc, two cycles.
// - add file, subtract file, add literal update carry, half carry, zero.
// - or, and, xor in both forms update only zero.
// - rotates go through carry, nine bits, carry only.
// - decrement/increment skip write result, skip when zero.
// - return with literal loads accumulator and pops stack, two cycles.
// - call and jump take low 12 bits from word, top from status 6.
// - stack 13 bits by 6; calls and entries push, returns pop.
// - instruction cycle is two phases; pc in first, latch in second.
`timescale 1ns/1ps
module rcpu_core import rcpu_pkg::*; #(
    parameter int NUM_IRQ = 8
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [13:0] i_rom_data,
    input wire logic [7:0] i_file_rdata,
    input wire logic [NUM_IRQ-1:0] i_irq_event,
    input wire logic [NUM_IRQ-1:0] i_irq_enable,
    output logic [12:0] o_rom_addr,
    output logic [6:0] o_file_addr,
    output logic o_file_we,
    output logic [7:0] o_file_wdata,
    output logic [5:0] o_wplane_addr,
    output logic o_wplane_we,
    output logic [7:0] o_wplane_wdata,
    output logic [7:0] o_status,
    output logic [7:0] o_acc,
    output logic o_in_service,
    output logic o_sleep,
    output logic o_wdt_kick
);
    rcpu_phase_t phase_q;
    logic [12:0] pc_q;
    logic [13:0] ir_q;
    logic [7:0] acc_q, status_q;
    logic isr_q, clr_isr_q, flush_q, sleep_q;
    logic [12:0] stack_top;
    logic push, pop;

    // decode fields of the latched word
    logic [1:0] g2;
    logic [2:0] g3;
    logic [3:0] bop;
    logic dbit;
    logic [7:0] lit;
    logic [2:0] bpos;
    logic exec;
    assign g2 = ir_q[13:12];
    assign g3 = ir_q[13:11];
    assign bop = ir_q[11:8];
    assign dbit = ir_q[7];
    assign lit = ir_q[7:0];
    assign bpos = ir_q[8:6];
    // execution happens in q2 with file data valid; flushed slots do nothing
    assign exec = (phase_q == RCPU_PH_Q2) && !flush_q;

    // alu and decoder, combinational
    logic [7:0] res, opnd, bmask;
    logic [8:0] sum;
    logic [4:0] nib;
    logic wr_acc, wr_file, wr_plane, upd_c, upd_dc, upd_z, res_c, res_dc;
    logic skip, branch, do_ret, do_return_from_interrupt, do_call, do_jump, do_sleep, do_kick;
    always_comb begin
        res = 8'h00;
        sum = 9'h000;
        nib = 5'h00;
        // status lives here, not in the file plane
        opnd = (o_file_addr == RCPU_STATUS_ADDR) ? status_q : i_file_rdata;
        bmask = 8'h01 << bpos;
        {wr_acc, wr_file, wr_plane, upd_c, upd_dc, upd_z} = 6'h00;
        {res_c, res_dc, skip, do_ret, do_return_from_interrupt} = 5'h00;
        {do_call, do_jump, do_sleep, do_kick} = 4'h0;
        if (g2 == RCPU_G_BYTE) begin
            case (bop)
                RCPU_B_MOVE_ACC_TO_FILE: begin
                    if (dbit) begin
                        res = acc_q;
                        wr_file = 1'b1;
                    end else if (ir_q == RCPU_OP_SLEEP) begin
                        do_sleep = 1'b1;
                    end else if (ir_q == RCPU_OP_KICK) begin
                        do_kick = 1'b1;
                    end else if (ir_q == RCPU_OP_RET) begin
                        do_ret = 1'b1;
                    end else if (ir_q == RCPU_OP_RETURN_FROM_INTERRUPT) begin
                        do_ret = 1'b1;
                        do_return_from_interrupt = 1'b1;
                    end else if (!ir_q[6]) begin
                        wr_plane = 1'b1;
                    end
                    // words with bit 6 set fall through idle; all-zero writes plane address 0
                end
                RCPU_B_CLR: begin
                    if (dbit) begin
                        wr_file = 1'b1;
                        upd_z = 1'b1;
                    end else if (ir_q == RCPU_OP_CLRW) begin
                        wr_acc = 1'b1;
                        upd_z = 1'b1;
                    end
                end
                RCPU_B_SUB: begin
                    // borrow-free gives carry 1
                    sum = {1'b0, opnd} + {1'b0, ~acc_q} + 9'h001;
                    nib = {1'b0, opnd[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;
                    res = sum[7:0];
                    {res_c, res_dc} = {sum[8], nib[4]};
                    {upd_c, upd_dc, upd_z} = 3'h7;
                end
                RCPU_B_ADD: begin
                    sum = {1'b0, opnd} + {1'b0, acc_q};
                    nib = {1'b0, opnd[3:0]} + {1'b0, acc_q[3:0]};
                    res = sum[7:0];
                    {res_c, res_dc} = {sum[8], nib[4]};
                    {upd_c, upd_dc, upd_z} = 3'h7;
                end
                RCPU_B_DEC: begin
                    res = opnd - 8'h01;
                    upd_z = 1'b1;
                end
                RCPU_B_IOR: begin
                    res = opnd | acc_q;
                    upd_z = 1'b1;
                end
                RCPU_B_AND: begin
                    res = opnd & acc_q;
                    upd_z = 1'b1;
                end
                RCPU_B_XOR: begin
                    res = opnd ^ acc_q;
                    upd_z = 1'b1;
                end
                RCPU_B_MOVF: begin
                    res = opnd; // d=1 is a zero test with no write
                    upd_z = 1'b1;
                    upd_z = dbit;
                    wr_acc = !dbit;
                end
                RCPU_B_COM: begin
                    res = ~opnd;
                    upd_z = 1'b1;
                end
                RCPU_B_INC: begin
                    res = opnd + 8'h01;
                    upd_z = 1'b1;
                end
                RCPU_B_DECSZ: begin
                    res = opnd - 8'h01;
                    skip = (res == 8'h00);
                end
                RCPU_B_INCSZ: begin
                    res = opnd + 8'h01;
                    skip = (res == 8'h00);
                end
                RCPU_B_RRC: begin
                    res = {status_q[RCPU_C_BIT], opnd[7:1]};
                    res_c = opnd[0];
                    upd_c = 1'b1;
                end
                RCPU_B_RLC: begin
                    res = {opnd[6:0], status_q[RCPU_C_BIT]};
                    res_c = opnd[7];
                    upd_c = 1'b1;
                end
                RCPU_B_SWAP: begin
                    res = {opnd[3:0], opnd[7:4]};
                end
                default: begin
                    res = 8'h00;
                end
            endcase
            // byte ops other than the control row, clear and movf route by d
            if (bop > RCPU_B_CLR && bop != RCPU_B_MOVF) begin
                wr_acc = !dbit;
                wr_file = dbit;
            end
        end else if (g3 == RCPU_G_BIT) begin
            // bit ops on 6-bit address
            case (ir_q[10:9])
                RCPU_BT_CLR: begin
                    res = opnd & ~bmask;
                    wr_file = 1'b1;
                end
                RCPU_BT_SET: begin
                    res = opnd | bmask;
                    wr_file = 1'b1;
                end
                RCPU_BT_SKC: skip = ((opnd & bmask) == 8'h00);
                RCPU_BT_SKS: skip = ((opnd & bmask) != 8'h00);
                default: skip = 1'b0;
            endcase
        end else if (g3 == RCPU_G_LIT) begin
            case (ir_q[10:8])
                RCPU_L_RETLIT: begin
                    res = lit;
                    wr_acc = 1'b1;
                    do_ret = 1'b1;
                end
                RCPU_L_MOV: begin
                    res = lit;
                    wr_acc = 1'b1;
                end
                RCPU_L_IOR: begin
                    res = lit | acc_q;
                    {wr_acc, upd_z} = 2'h3;
                end
                RCPU_L_AND: begin
                    res = lit & acc_q;
                    {wr_acc, upd_z} = 2'h3;
                end
                RCPU_L_XOR: begin
                    res = lit ^ acc_q;
                    {wr_acc, upd_z} = 2'h3;
                end
                RCPU_L_ADD: begin
                    sum = {1'b0, lit} + {1'b0, acc_q};
                    nib = {1'b0, lit[3:0]} + {1'b0, acc_q[3:0]};
                    res = sum[7:0];
                    {res_c, res_dc} = {sum[8], nib[4]};
                    {wr_acc, upd_c, upd_dc, upd_z} = 4'hF;
                end
                default: res = 8'h00; // undefined literal ops idle
            endcase
        end else if (g2 == RCPU_G_CALL) begin
            do_call = 1'b1;
        end else begin
            do_jump = 1'b1;
        end
    end
    // branches and skips cost one flushed slot
    assign branch = do_call || do_jump || do_ret || skip;

    // interrupt request: level on enabled flags, blocked while busy
    logic irq_req;
    assign irq_req = |(i_irq_event & i_irq_enable) && !isr_q;
    logic take_irq;
    assign take_irq = exec && irq_req && !branch;
    logic [12:0] target;
    assign target = {status_q[RCPU_PAGE_BIT], ir_q[11:0]};
    // status addressed as destination of any file write; flag writers
    logic st_dst, flag_op;
    assign st_dst = wr_file && (o_file_addr == RCPU_STATUS_ADDR);
    assign flag_op = upd_c || upd_dc || upd_z;
    assign push = (exec && do_call) || take_irq;
    assign pop = exec && do_ret;

    rcpu_stack #(.WIDTH(RCPU_PCW), .DEPTH(RCPU_STACK_DEPTH)) u_stack (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_push(push),
        .i_pop(pop),
        .i_data(pc_q - 13'h0001), // pc runs two words ahead of execution
        .o_top(stack_top)
    );

    // phase toggle halves the clock; stops while asleep
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            phase_q <= RCPU_PH_Q1;
        end else if (!sleep_q) begin
            phase_q <= (phase_q == RCPU_PH_Q1) ? RCPU_PH_Q2 : RCPU_PH_Q1;
        end
    end

    // pc: advance in q1, redirect from the executing word in q2
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            pc_q <= RCPU_RESET_VEC;
        end else if (phase_q == RCPU_PH_Q1 && !sleep_q) begin
            pc_q <= pc_q + 13'h0001;
        end else if (take_irq) begin
            pc_q <= RCPU_INT_VEC;
        end else if (exec && (do_call || do_jump)) begin
            pc_q <= target;
        end else if (pop) begin
            pc_q <= stack_top;
        end
    end

    // rom address in q1, instruction latch in q2
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_rom_addr <= RCPU_RESET_VEC;
            ir_q <= RCPU_OP_NOP;
            flush_q <= 1'b1;
        end else if (phase_q == RCPU_PH_Q1) begin
            o_rom_addr <= pc_q;
        end else if (!sleep_q) begin
            ir_q <= i_rom_data;
            flush_q <= exec ? (branch || take_irq) : 1'b0;
        end
    end

    // accumulator
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            acc_q <= 8'h00;
        end else if (exec && wr_acc) begin
            acc_q <= res;
        end
    end

    // status: flag results override a direct write to those bits
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            status_q <= RCPU_STATUS_RST;
        end else if (exec) begin
            if (st_dst) begin
                status_q <= flag_op ? {res[7:3], status_q[2:0]} : res;
            end
            if (upd_c) status_q[RCPU_C_BIT] <= res_c;
            if (upd_dc) status_q[RCPU_DC_BIT] <= res_dc;
            if (upd_z) status_q[RCPU_Z_BIT] <= (res == 8'h00);
        end
    end

    // busy flag: set on entry, cleared after the word following return
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            isr_q <= 1'b0;
            clr_isr_q <= 1'b0;
        end else if (take_irq) begin
            isr_q <= 1'b1;
        end else if (exec) begin
            if (clr_isr_q && !flush_q) isr_q <= 1'b0;
            clr_isr_q <= do_return_from_interrupt ? 1'b1 : 1'b0;
        end
    end

    // file and write-only plane ports, registered for the next edge
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_file_addr <= 7'h00;
            o_file_we <= 1'b0;
            o_file_wdata <= 8'h00;
            o_wplane_addr <= 6'h00;
            o_wplane_we <= 1'b0;
            o_wplane_wdata <= 8'h00;
        end else begin
            if (phase_q == RCPU_PH_Q1) begin
                // bit ops use only a 6-bit address
                o_file_addr <= (ir_q[13:12] == 2'h1) ? {1'b0, ir_q[5:0]}
                                                     : ir_q[6:0];
            end
            o_file_we <= exec && wr_file && !st_dst;
            o_file_wdata <= res;
            o_wplane_we <= exec && wr_plane;
            o_wplane_addr <= ir_q[5:0];
            o_wplane_wdata <= acc_q;
        end
    end

    // sleep latch and kick pulse; a request wakes the core
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sleep_q <= 1'b0;
            o_wdt_kick <= 1'b0;
        end else begin
            o_wdt_kick <= exec && do_kick;
            if (exec && do_sleep) sleep_q <= 1'b1;
            else if (|(i_irq_event & i_irq_enable)) sleep_q <= 1'b0;
        end
    end

    assign o_status = status_q;
    assign o_acc = acc_q;
    assign o_in_service = isr_q;
    assign o_sleep = sleep_q;
endmodule : rcpu_core

// *** verification/rcpu_core_monitor.sv ***
// rcpu_core_monitor: port timing checks for the 8-bit core
// assumes one clock domain and an async active-high reset
`timescale 1ns/1ps
module rcpu_core_monitor import rcpu_pkg::*; #(
    parameter int NUM_IRQ = 8
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [NUM_IRQ-1:0] i_irq_event,
    input wire logic [NUM_IRQ-1:0] i_irq_enable,
    input wire logic [12:0] o_rom_addr,
    input wire logic o_file_we,
    input wire logic o_wplane_we,
    input wire logic o_in_service,
    input wire logic o_sleep,
    input wire logic o_wdt_kick
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);
    logic req;
    // any enabled source pending
    assign req = |(i_irq_event & i_irq_enable);
    // interrupt entry: busy flag rises, then the vector is fetched
    sequence s_entry;
        $rose(o_in_service);
    endsequence
    sequence s_vector;
        o_rom_addr == RCPU_INT_VEC;
    endsequence
    file_pulse_a: assert property (o_file_we |=> !o_file_we)
        else $error("file write pulse longer than one clock");
    plane_pulse_a: assert property (o_wplane_we |=> !o_wplane_we)
        else $error("plane write pulse longer than one clock");
    kick_pulse_a: assert property (o_wdt_kick |=> !o_wdt_kick)
        else $error("watchdog kick longer than one clock");
    isr_cause_a: assert property (s_entry |-> $past(req))
        else $error("service entered without enabled request");
    isr_vector_a: assert property (s_entry |-> ##[0:4] s_vector)
        else $error("vector not fetched after entry");
    isr_hold_a: assert property (s_entry |=> o_in_service [*4])
        else $error("busy flag dropped early");
    sleep_hold_a: assert property (o_sleep && !req |=> o_sleep)
        else $error("standby left without request");
    pc_phase_a: assert property ($changed(o_rom_addr)
        |=> $stable(o_rom_addr))
        else $error("fetch address moved on two edges");
    sleep_quiet_a: assert property (o_sleep && $past(o_sleep, 2)
        |-> !o_file_we && !o_wplane_we)
        else $error("write while in standby");
endmodule : rcpu_core_monitor

bind rcpu_core rcpu_core_monitor #(.NUM_IRQ(NUM_IRQ)) i_rcpu_core_monitor (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_irq_event(i_irq_event),
    .i_irq_enable(i_irq_enable), .o_rom_addr(o_rom_addr),
    .o_file_we(o_file_we), .o_wplane_we(o_wplane_we),
    .o_in_service(o_in_service), .o_sleep(o_sleep), .o_wdt_kick(o_wdt_kick)
);

// *** verification/rcpu_mem_model.sv ***
// rcpu_mem_model: program rom, file plane and write-only plane
// assumes the bench loads rom before reset is released
`timescale 1ns/1ps
module rcpu_mem_model (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [12:0] i_rom_addr,
    input wire logic [6:0] i_file_addr,
    input wire logic i_file_we,
    input wire logic [7:0] i_file_wdata,
    input wire logic [5:0] i_wplane_addr,
    input wire logic i_wplane_we,
    input wire logic [7:0] i_wplane_wdata,
    output logic [13:0] o_rom_data,
    output logic [7:0] o_file_rdata
);
    logic [13:0] rom [0:63];
    logic [7:0] ram [0:127];
    logic [7:0] wpl [0:63];
    logic [63:0] wseen;
    // unregistered reads: data stands by the edge after the address
    assign o_rom_data = rom[i_rom_addr[5:0]];
    assign o_file_rdata = ram[i_file_addr];
    always_ff @(posedge i_mclk) begin
        if (i_file_we) begin
            ram[i_file_addr] <= i_file_wdata;
        end
        if (i_wplane_we) begin
            wpl[i_wplane_addr] <= i_wplane_wdata;
        end
    end
    // record which write-only places were hit, to catch skipped ones
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            wseen <= 64'h0;
        end else if (i_wplane_we) begin
            wseen[i_wplane_addr] <= 1'b1;
        end
    end
endmodule : rcpu_mem_model

// *** verification/rcpu_core_tb.sv ***
// rcpu_core_tb: runs a fixed program and checks the results it leaves
// assumes rcpu_mem_model as rom and data planes
`timescale 1ns/1ps
module rcpu_core_tb;
    logic i_mclk;
    logic i_reset;
    logic [13:0] rom_data;
    logic [7:0] file_rdata, file_wdata, wplane_wdata, acc, irq_ev, irq_en;
    logic [12:0] rom_addr;
    logic [6:0] file_addr;
    logic [5:0] wplane_addr;
    logic file_we, wplane_we, in_service, sleep, kick;
    int mismatches = 0;
    int comparisons = 0;
    logic [7:0] kicks;
    // vector jumps, call target 02, handler 04, main code from 10
    logic [13:0] prog [0:63] = '{
        14'h3010, 14'h3004, 14'h185A, 14'h0000, 14'h19A5, 14'h003F, 14'h0060,
        14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000,
        14'h0000, 14'h0000, 14'h190F, 14'h1C01, 14'h0001, 14'h0803, 14'h0002,
        14'h1910, 14'h00A0, 14'h0220, 14'h0803, 14'h0011, 14'h1901, 14'h0220,
        14'h0012, 14'h0803, 14'h0005, 14'h0CA0, 14'h0820, 14'h0006, 14'h0803,
        14'h0007, 14'h1FFF, 14'h1FFF, 14'h0803, 14'h0008, 14'h1901, 14'h00A1,
        14'h0BA1, 14'h0009, 14'h000A, 14'h1621, 14'h000B, 14'h1221, 14'h1621,
        14'h000C, 14'h000D, 14'h192C, 14'h0783, 14'h0803, 14'h000E, 14'h2002,
        14'h000F, 14'h1A00, 14'h0010, 14'h0004, 14'h0003, 14'h0000, 14'h303D,
        14'h0000};
    // expected plane writes as {address, value}
    logic [13:0] exp_w [0:13] = '{14'h0110, 14'h0202, 14'h1107, 14'h120F,
        14'h0501, 14'h0688, 14'h0700, 14'h0804, 14'h0A01, 14'h0B01, 14'h0D01,
        14'h0E32, 14'h0F5A, 14'h105A};

    rcpu_core i_rcpu_core (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_rom_data(rom_data), .i_file_rdata(file_rdata),
        .i_irq_event(irq_ev), .i_irq_enable(irq_en), .o_rom_addr(rom_addr),
        .o_file_addr(file_addr), .o_file_we(file_we),
        .o_file_wdata(file_wdata), .o_wplane_addr(wplane_addr),
        .o_wplane_we(wplane_we), .o_wplane_wdata(wplane_wdata),
        .o_status(), .o_acc(acc), .o_in_service(in_service),
        .o_sleep(sleep), .o_wdt_kick(kick));
    rcpu_mem_model i_rcpu_mem_model (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_rom_addr(rom_addr), .i_file_addr(file_addr), .i_file_we(file_we),
        .i_file_wdata(file_wdata), .i_wplane_addr(wplane_addr),
        .i_wplane_we(wplane_we), .i_wplane_wdata(wplane_wdata),
        .o_rom_data(rom_data), .o_file_rdata(file_rdata));

    task automatic chk8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic chk1(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask : chk1
    task automatic end_of_test;
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // free-running crystal clock, 50 ns
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    // kick pulses must come once, one clock each
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) kicks <= 8'h00;
        else if (kick === 1'b1) kicks <= kicks + 8'h01;
    end
    // hang guard, far beyond the ~500 clocks the run needs
    initial begin
        #(2000 * 50);
        mismatches++;
        end_of_test;
    end
    // main sequence
    initial begin
        irq_ev = 8'h00;
        irq_en = 8'h00;
        i_reset = 1'b1;
        for (int i = 0; i < 64; i++) i_rcpu_mem_model.rom[i] = prog[i];
        repeat (3) @(negedge i_mclk);
        i_reset = 1'b0;
        repeat (400) @(negedge i_mclk);
        foreach (exp_w[k]) begin
            chk1("plane hit", 1'b1, i_rcpu_mem_model.wseen[exp_w[k][13:8]]);
            chk8("plane", exp_w[k][7:0], i_rcpu_mem_model.wpl[exp_w[k][13:8]]);
        end
        chk1("skip 09", 1'b0, i_rcpu_mem_model.wseen[6'h09]);
        chk1("skip 0C", 1'b0, i_rcpu_mem_model.wseen[6'h0C]);
        chk8("file 20", 8'h88, i_rcpu_mem_model.ram[7'h20]);
        chk8("file 21", 8'h01, i_rcpu_mem_model.ram[7'h21]);
        chk8("kicks", 8'h01, kicks);
        chk1("sleep", 1'b1, sleep);
        irq_ev = 8'h08;
        repeat (50) @(negedge i_mclk);
        chk1("masked sleep", 1'b1, sleep);
        chk1("masked entry", 1'b0, i_rcpu_mem_model.wseen[6'h3F]);
        irq_en = 8'h08;
        for (int n = 0; n < 200 && i_rcpu_mem_model.wseen[6'h3F] !== 1'b1; n++)
            @(negedge i_mclk);
        chk1("in service", 1'b1, in_service);
        irq_ev = 8'h00; // bench clears the event in the handler's place
        repeat (40) @(negedge i_mclk);
        chk1("service done", 1'b0, in_service);
        chk1("woken", 1'b0, sleep);
        chk8("handler", 8'hA5, i_rcpu_mem_model.wpl[6'h3F]);
        chk8("acc", 8'hA5, acc);
        end_of_test;
    end
endmodule : rcpu_core_tb
